// ### design/stopwatch_regs.svh
`ifndef STOPWATCH_REGS_SVH
`define STOPWATCH_REGS_SVH

// register offsets as printed; the index inside the block is offset - base
`define SW_BASE_OFS 16'h5020
`define SW_CTRL_OFS 16'h5020
`define SW_COUNT_OFS 16'h5021
`define SW_MASK_OFS 16'h5022
`define SW_FLAGS_OFS 16'h5023

// two-bit register index carried over the link
`define SW_CTRL_IDX 2'h0
`define SW_COUNT_IDX 2'h1
`define SW_MASK_IDX 2'h2
`define SW_FLAGS_IDX 2'h3

// bus byte address is four times the printed offset
`define SW_BUS_CTRL_ADDR 32'h00014080
`define SW_BUS_COUNT_ADDR 32'h00014084
`define SW_BUS_MASK_ADDR 32'h00014088
`define SW_BUS_FLAGS_ADDR 32'h0001408C
`define SW_BUS_STATUS_ADDR 32'h00000000

// control register fields
`define SW_CTRL_RUN_BIT 0
`define SW_CTRL_CLEAR_BIT 4

// count register fields
`define SW_TENTHS_MSB 7
`define SW_TENTHS_LSB 4
`define SW_HUND_MSB 3
`define SW_HUND_LSB 0

// mask and flag bit positions
`define SW_HZ100_BIT 0
`define SW_HZ10_BIT 1
`define SW_HZ1_BIT 2
`define SW_SRC_N 3

// reset values
`define SW_CTRL_RST 8'h00
`define SW_COUNT_RST 8'h00
`define SW_MASK_RST 3'h0
`define SW_FLAGS_RST 3'h0
`define SW_DIGIT_RST 4'h0

// controller status register
`define SW_STAT_IRQ_BIT 0

// bcd limits and 4:6 level threshold
`define SW_DIGIT_MAX 4'h9
`define SW_LEVEL_HIGH_FROM 4'h6

// hundredths step: last sub index for the 2-period and 3-period intervals
`define SW_SUB_LAST_SHORT 2'h1
`define SW_SUB_LAST_LONG 2'h2

// timing: system clock and operating clock rates in Hz
`define SW_CLK_HZ 100000000
`define SW_OSC_HZ 256
`define SW_TICK_DIV (`SW_CLK_HZ / `SW_OSC_HZ)
`define SW_DIV_W 19

`endif

// ### design/stopwatch_pkg.sv
package stopwatch_pkg;

    // device state, registered as one word
    typedef struct packed {
        logic [18:0] div;
        logic run;
        logic run_req;
        logic [1:0] sub;
        logic alt;
        logic [3:0] hund;
        logic [3:0] tenth;
        logic [2:0] prev;
        logic [2:0] mask;
        logic [2:0] flags;
        logic [7:0] rdata;
    } dev_state_t;

    // controller bus states, gray along idle-strobe-wait-done
    typedef enum logic [1:0] {
        CTL_IDLE = 2'b00,
        CTL_STROBE = 2'b01,
        CTL_WAITD = 2'b11,
        CTL_DONE = 2'b10
    } ctl_fsm_t;

    typedef enum logic [1:0] {
        TGT_NONE = 2'b00,
        TGT_DEV = 2'b01,
        TGT_STAT = 2'b10
    } ctl_tgt_t;

    typedef struct packed {
        ctl_fsm_t fsm;
        ctl_tgt_t tgt;
        logic [1:0] idx;
        logic wr;
        logic [31:0] hrdata;
        logic irq;
    } ctl_state_t;

endpackage

// ### design/stopwatch_link_if.sv
`timescale 1ns/1ns
interface stopwatch_link_if;
    logic [1:0] reg_idx;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic irq;

    modport device (
        input reg_idx,
        input reg_wr,
        input reg_rd,
        input reg_wdata,
        output reg_rdata,
        output irq
    );

    modport controller (
        output reg_idx,
        output reg_wr,
        output reg_rd,
        output reg_wdata,
        input reg_rdata,
        input irq
    );
endinterface

// ### design/stopwatch_timer.sv
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "stopwatch_regs.svh"

// Functional notes
// R01: reserved register bits read as zero
// R02: software writes zero to reserved bits
// R03: clear bit zeroes both digits, reads zero
// R04: clear while running keeps counting from zero
// R05: clear while stopped holds zero until run
// R06: run bit starts and stops, resets zero
// R07: stopped counter holds its value
// R08: count holds tenths high, hundredths low
// R09: count register is read only
// R10: software stops or double-reads for stable count
// R11: mask holds three enables, reset zero
// R12: enabled falling rate edge sets its flag
// R13: interrupt request high while any flag set
// R14: writing one clears flag, zero ignored
// R15: interrupt controller input is level triggered
// R16: software clears flags before enabling them
// R17: controller enable also gates the interrupt
// R18: counting runs from 256 Hz operating rate
// R19: hundredths advance alternately after 2, 3 periods
// R20: tenths count 10 Hz carry, 4:6 ratio
// R21: run/stop act on next tick, reads hold
// R22: writes resynchronised to tick, edges detected there; only the run request is, clear and flag clears act at once
module stopwatch_timer #(
    parameter int unsigned TICK_DIV = `SW_TICK_DIV
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    stopwatch_link_if.device link,
    output logic running_out,
    output logic [7:0] count_out
);

    stopwatch_pkg::dev_state_t s_ff;
    stopwatch_pkg::dev_state_t nxt_s;

    logic tick;
    logic [2:0] lvl;
    logic [2:0] fall;
    logic [2:0] clr;
    logic [1:0] sub_last;
    genvar gi;

    // per-source write-one clear; a zero bit leaves its flag alone
    // decoded straight from the link so the flag merge below sees no feedback
    generate
        for (gi = 0; gi < `SW_SRC_N; gi = gi + 1) begin : g_src_clr
            assign clr[gi] = link.reg_wr && (link.reg_idx == `SW_FLAGS_IDX) &&
                             link.reg_wdata[gi]; // see R14
        end
    endgenerate

    // rate levels: 100 Hz falls at each step, 10 Hz and 1 Hz are high for 4 of 10 counts
    function automatic logic [2:0] levels(input stopwatch_pkg::dev_state_t v);
        logic [2:0] l;
        l = 3'h0;
        l[`SW_HZ100_BIT] = (v.sub != 2'h0);
        l[`SW_HZ10_BIT] = (v.hund >= `SW_LEVEL_HIGH_FROM); // see R20
        l[`SW_HZ1_BIT] = (v.tenth >= `SW_LEVEL_HIGH_FROM);
        return l;
    endfunction

    // read view of the selected register
    function automatic logic [7:0] read_view(input stopwatch_pkg::dev_state_t v,
                                             input logic [1:0] idx);
        logic [7:0] r;
        r = 8'h00;
        if (idx == `SW_CTRL_IDX) begin
            // clear bit reads zero; run reads one until really stopped
            r[`SW_CTRL_RUN_BIT] = v.run | v.run_req; // see R21 see R03 see R01
        end else if (idx == `SW_COUNT_IDX) begin
            r[`SW_TENTHS_MSB:`SW_TENTHS_LSB] = v.tenth; // see R08
            r[`SW_HUND_MSB:`SW_HUND_LSB] = v.hund;
        end else if (idx == `SW_MASK_IDX) begin
            r[2:0] = v.mask; // see R01
        end else begin
            r[2:0] = v.flags; // see R01
        end
        return r;
    endfunction

    // next-state logic
    always_comb begin
        nxt_s = s_ff;
        fall = 3'h0;
        lvl = 3'h0;
        sub_last = s_ff.alt ? `SW_SUB_LAST_LONG : `SW_SUB_LAST_SHORT;

        // 256 Hz operating rate as a one-cycle enable from the divider
        tick = (s_ff.div == `SW_DIV_W'(TICK_DIV - 1)); // see R18
        if (tick) begin
            nxt_s.div = '0;
        end else begin
            nxt_s.div = s_ff.div + `SW_DIV_W'(1);
        end

        // counting only on a tick while running; stopped state holds digits
        if (tick && s_ff.run) begin // see R07
            if (s_ff.sub == sub_last) begin
                // alternate 2 and 3 ticks per hundredth
                nxt_s.sub = 2'h0; // see R19
                nxt_s.alt = ~s_ff.alt;
                if (s_ff.hund == `SW_DIGIT_MAX) begin
                    nxt_s.hund = `SW_DIGIT_RST;
                    // tenths take the 10 Hz carry
                    if (s_ff.tenth == `SW_DIGIT_MAX) begin // see R20
                        nxt_s.tenth = `SW_DIGIT_RST;
                    end else begin
                        nxt_s.tenth = s_ff.tenth + 4'h1;
                    end
                end else begin
                    nxt_s.hund = s_ff.hund + 4'h1;
                end
            end else begin
                nxt_s.sub = s_ff.sub + 2'h1;
            end
        end

        // run request is taken over only at a tick, so a stop still lets that tick count
        if (tick) begin
            nxt_s.run = s_ff.run_req; // see R21 see R22
            lvl = levels(nxt_s);
            fall = s_ff.prev & ~lvl; // see R22
            nxt_s.prev = lvl;
        end

        // register writes
        if (link.reg_wr) begin
            if (link.reg_idx == `SW_CTRL_IDX) begin
                nxt_s.run_req = link.reg_wdata[`SW_CTRL_RUN_BIT]; // see R06
                if (link.reg_wdata[`SW_CTRL_CLEAR_BIT]) begin
                    // clear now; run follows bit 0 of this same write, so a running timer goes on only if run is written one
                    nxt_s.hund = `SW_DIGIT_RST; // see R03 see R04 see R05
                    nxt_s.tenth = `SW_DIGIT_RST;
                    nxt_s.sub = 2'h0;
                    nxt_s.alt = 1'b0;
                    nxt_s.prev = 3'h0; // avoids a false falling edge from the clear
                end
            end else if (link.reg_idx == `SW_MASK_IDX) begin
                nxt_s.mask = link.reg_wdata[2:0]; // see R11
            end
            // flag writes act only through the per-source clear strobes
            // count register writes fall through untouched
        end // see R09

        // flags: set wins over a clear in the same cycle
        nxt_s.flags = (s_ff.flags & ~clr) | (fall & s_ff.mask); // see R12 see R14

        // read data registered one cycle after the strobe
        if (link.reg_rd) begin
            nxt_s.rdata = read_view(s_ff, link.reg_idx);
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs
    assign link.reg_rdata = s_ff.rdata;
    assign link.irq = |s_ff.flags; // see R13
    assign running_out = s_ff.run;
    assign count_out = {s_ff.tenth, s_ff.hund};

endmodule

// ### design/stopwatch_ctl.sv
`timescale 1ns/1ns
`include "stopwatch_regs.svh"

module stopwatch_ctl (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    output logic irq_out,
    stopwatch_link_if.controller link
);

    stopwatch_pkg::ctl_state_t s_ff;
    stopwatch_pkg::ctl_state_t nxt_s;
    logic take;
    logic strobe_dev;

    // hsize is always a word here; only selection, transfer type and hready matter
    assign take = hsel_in && htrans_in[1] && hready_in &&
                  (s_ff.fsm == stopwatch_pkg::CTL_IDLE || s_ff.fsm == stopwatch_pkg::CTL_DONE);
    assign strobe_dev = (s_ff.fsm == stopwatch_pkg::CTL_STROBE) &&
                        (s_ff.tgt == stopwatch_pkg::TGT_DEV);

    // next-state logic
    always_comb begin
        nxt_s = s_ff;
        nxt_s.irq = link.irq; // level input for the interrupt controller, see R15
        case (s_ff.fsm)
            stopwatch_pkg::CTL_STROBE: begin
                if (s_ff.tgt == stopwatch_pkg::TGT_DEV && !s_ff.wr) begin
                    nxt_s.fsm = stopwatch_pkg::CTL_WAITD;
                end else begin
                    nxt_s.fsm = stopwatch_pkg::CTL_DONE;
                    if (s_ff.tgt == stopwatch_pkg::TGT_STAT) begin
                        nxt_s.hrdata = 32'h00000000;
                        nxt_s.hrdata[`SW_STAT_IRQ_BIT] = s_ff.irq;
                    end
                end
            end
            stopwatch_pkg::CTL_WAITD: begin
                nxt_s.hrdata = {24'h000000, link.reg_rdata};
                nxt_s.fsm = stopwatch_pkg::CTL_DONE;
            end
            default: begin
                nxt_s.fsm = stopwatch_pkg::CTL_IDLE;
            end
        endcase
        // address phase accepted; decode to a device register or own status
        if (take) begin
            nxt_s.fsm = stopwatch_pkg::CTL_STROBE;
            nxt_s.wr = hwrite_in;
            nxt_s.hrdata = 32'h00000000;
            if (haddr_in == `SW_BUS_CTRL_ADDR) begin
                nxt_s.tgt = stopwatch_pkg::TGT_DEV;
                nxt_s.idx = `SW_CTRL_IDX;
            end else if (haddr_in == `SW_BUS_COUNT_ADDR) begin
                nxt_s.tgt = stopwatch_pkg::TGT_DEV;
                nxt_s.idx = `SW_COUNT_IDX;
            end else if (haddr_in == `SW_BUS_MASK_ADDR) begin
                nxt_s.tgt = stopwatch_pkg::TGT_DEV;
                nxt_s.idx = `SW_MASK_IDX;
            end else if (haddr_in == `SW_BUS_FLAGS_ADDR) begin
                nxt_s.tgt = stopwatch_pkg::TGT_DEV;
                nxt_s.idx = `SW_FLAGS_IDX;
            end else if (haddr_in == `SW_BUS_STATUS_ADDR) begin
                nxt_s.tgt = stopwatch_pkg::TGT_STAT;
                nxt_s.idx = 2'h0;
            end else begin
                // unmapped: reads zero, writes dropped
                nxt_s.tgt = stopwatch_pkg::TGT_NONE;
                nxt_s.idx = 2'h0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // link strobes; reserved bits of hwdata pass as written by software, see R02
    assign link.reg_idx = s_ff.idx;
    assign link.reg_wr = strobe_dev && s_ff.wr;
    assign link.reg_rd = strobe_dev && !s_ff.wr;
    assign link.reg_wdata = hwdata_in[7:0];

    assign hreadyout_out = (s_ff.fsm == stopwatch_pkg::CTL_IDLE) ||
                           (s_ff.fsm == stopwatch_pkg::CTL_DONE);
    assign hresp_out = 1'b0;
    assign hrdata_out = s_ff.hrdata;
    // request only; the interrupt controller still applies its own enable, see R17
    assign irq_out = s_ff.irq; // see R13

endmodule

// ### bench/stopwatch_chk.sv
`timescale 1ns/1ns
module stopwatch_chk (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [1:0] reg_idx,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic irq,
    input wire logic running_out,
    input wire logic [7:0] count_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // link strobes: one at a time, never in adjacent cycles
    property p_strobe_gap;
        (reg_wr || reg_rd) |=> !(reg_wr || reg_rd);
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("link strobes too close");
    // clear zeroes both digits at the write edge
    property p_clear;
        (reg_wr && reg_idx == 2'h0 && reg_wdata[4]) |=> count_out == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left digits");
    property p_bcd;
        count_out[3:0] <= 4'h9 && count_out[7:4] <= 4'h9;
    endproperty
    a_bcd: assert property (p_bcd) else $error("digit out of bcd range");
    // stopped counter holds unless a control write intervenes
    property p_hold;
        (!running_out && !(reg_wr && reg_idx == 2'h0)) |=> (running_out || $stable(count_out));
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");
    property p_hund_step;
        $changed(count_out[3:0]) |->
            (count_out[3:0] == $past(count_out[3:0]) + 4'h1 || count_out[3:0] == 4'h0);
    endproperty
    a_hund_step: assert property (p_hund_step) else $error("hundredths skipped");
    property p_tenth_carry;
        $changed(count_out[7:4]) |-> count_out[3:0] == 4'h0;
    endproperty
    a_tenth_carry: assert property (p_tenth_carry) else $error("tenths moved without carry");
    // read data of count, control and flags one cycle after the read strobe
    property p_count_read;
        (reg_rd && reg_idx == 2'h1) |=> reg_rdata == $past(count_out);
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read wrong");
    property p_ctrl_read;
        (reg_rd && reg_idx == 2'h0) |=> reg_rdata[7:1] == 7'h00;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl reserved bits set");
    property p_run_read;
        (reg_rd && reg_idx == 2'h0 && running_out) |=> reg_rdata[0];
    endproperty
    a_run_read: assert property (p_run_read) else $error("run bit low while running");
    property p_flag_read;
        (reg_rd && reg_idx == 2'h3) |=> (reg_rdata[7:3] == 5'h00 && |reg_rdata[2:0] == $past(irq));
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flags and irq disagree");
    c_irq: cover property (irq);
    c_clr_run: cover property (reg_wr && reg_idx == 2'h0 && reg_wdata[4] && running_out);
    c_stop: cover property ($fell(running_out));
endmodule

// ### bench/test_bcd_stopwatch_timer.sv
`timescale 1ns/1ns
`include "stopwatch_regs.svh"
module test_bcd_stopwatch_timer;
    localparam logic [31:0] CTL_A = `SW_BUS_CTRL_ADDR;
    localparam logic [31:0] CNT_A = `SW_BUS_COUNT_ADDR;
    localparam logic [31:0] MSK_A = `SW_BUS_MASK_ADDR;
    localparam logic [31:0] FLG_A = `SW_BUS_FLAGS_ADDR;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, c1;
    logic hready, hresp, irq, running, watch = 1'b0;
    logic [7:0] count;
    logic [3:0] hund_ff = 4'h0;
    int mismatches = 0, n_compared = 0, gap = 0, prev_gap = 0, steps = 0;

    stopwatch_link_if link ();
    stopwatch_ctl stopwatch_ctl_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
        .hrdata_out(hrdata), .irq_out(irq), .link(link.controller));
    stopwatch_timer #(.TICK_DIV(4)) stopwatch_timer_inst (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .link(link.device), .running_out(running), .count_out(count));
    stopwatch_chk chk_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_idx(link.reg_idx),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_wdata(link.reg_wdata),
        .reg_rdata(link.reg_rdata), .irq(link.irq), .running_out(running), .count_out(count));

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one single transfer; hready sampled at each rising edge, phases move only after it
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_in); while (hready !== 1'b1);
        rv = hrdata;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 32'h0);
        check(nm, rv, exp);
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // two successive hundredths intervals must total 2+3 ticks of 4 cycles
    always @(negedge clk_in) begin
        hund_ff <= count[3:0];
        gap <= gap + 1;
        if (!watch) begin
            steps <= 0;
        end else if (count[3:0] !== hund_ff) begin
            if (steps >= 2) check("hund pace", gap + 1 + prev_gap, 32'h14);
            prev_gap <= gap + 1;
            gap <= 0;
            steps <= steps + 1;
        end
    end

    // hang guard, well above the expected run length
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rd(CTL_A, 32'h0, "ctrl reset");
        rd(CNT_A, 32'h0, "count reset");
        rd(MSK_A, 32'h0, "mask reset");
        rd(FLG_A, 32'h0, "flags reset");
        rd(32'h0, 32'h0, "status reset");
        rd(32'h100, 32'h0, "unmapped");
        check("unmapped resp", {31'h0, hresp}, 32'h0);
        xfer(1'b1, MSK_A, 32'h7);
        rd(MSK_A, 32'h7, "mask rw");
        xfer(1'b1, MSK_A, 32'h0);
        xfer(1'b1, CNT_A, 32'h55);
        rd(CNT_A, 32'h0, "count ro");
        // masked run: digits move, flags stay clear
        xfer(1'b1, CTL_A, 32'h1);
        rd(CTL_A, 32'h1, "run bit");
        repeat (300) @(posedge clk_in);
        xfer(1'b1, CTL_A, 32'h0);
        repeat (20) @(posedge clk_in);
        rd(CTL_A, 32'h0, "stopped");
        xfer(1'b0, CNT_A, 32'h0);
        c1 = rv;
        check("count moved", {31'h0, c1 == 32'h0}, 32'h0);
        repeat (50) @(posedge clk_in);
        rd(CNT_A, c1, "count held");
        rd(FLG_A, 32'h0, "masked flags");
        // clear while stopped
        xfer(1'b1, CTL_A, 32'h10);
        rd(CNT_A, 32'h0, "clear stopped");
        repeat (50) @(posedge clk_in);
        rd(CNT_A, 32'h0, "clear hold");
        rd(CTL_A, 32'h0, "clear bit reads 0");
        // full second with every source enabled, flags cleared first
        xfer(1'b1, FLG_A, 32'h7);
        xfer(1'b1, MSK_A, 32'h7);
        xfer(1'b1, CTL_A, 32'h1);
        watch <= 1'b1;
        repeat (1300) @(posedge clk_in);
        watch <= 1'b0;
        xfer(1'b1, CTL_A, 32'h0);
        repeat (20) @(posedge clk_in);
        rd(FLG_A, 32'h7, "all flags");
        rd(32'h0, 32'h1, "irq high");
        check("irq pin high", {31'h0, irq}, 32'h1);
        xfer(1'b1, FLG_A, 32'h2);
        rd(FLG_A, 32'h5, "w1c one");
        xfer(1'b1, FLG_A, 32'h5);
        rd(FLG_A, 32'h0, "w1c rest");
        rd(32'h0, 32'h0, "irq low");
        check("irq pin low", {31'h0, irq}, 32'h0);
        // clear while running keeps the run going
        xfer(1'b1, CTL_A, 32'h1);
        repeat (100) @(posedge clk_in);
        xfer(1'b1, CTL_A, 32'h11);
        rd(CNT_A, 32'h0, "clear running");
        rd(CTL_A, 32'h1, "still running");
        repeat (100) @(posedge clk_in);
        xfer(1'b1, CTL_A, 32'h0);
        repeat (20) @(posedge clk_in);
        xfer(1'b0, CNT_A, 32'h0);
        check("resumed", {31'h0, rv == 32'h0}, 32'h0);
        finish_test();
    end
endmodule
